// *** tcid_cfg.svh ***
`ifndef TCID_CFG_SVH
`define TCID_CFG_SVH

// system register selector encodings {op0, op1, crn, crm, op2}
`define TCID_SEL_W 16
`define TCID_SEL_ID_TEN 16'h8816
`define TCID_SEL_ID_ELEVEN 16'h881e
`define TCID_SEL_ID_TWELVE 16'h8826
`define TCID_SEL_ID_THIRTEEN 16'h882e
`define TCID_SEL_ID_MAIN 16'h8847

// main id register field positions
`define TCID_TRANS_KIND_BIT 30
`define TCID_COMMIT_OPT_BIT 29
`define TCID_TS_SIZE_LSB 24
`define TCID_Q_ELEM_LSB 14
`define TCID_EVT_CNT_LSB 10
`define TCID_RET_STACK_BIT 9
`define TCID_CYC_CNT_BIT 7
`define TCID_COND_TRACE_BIT 6
`define TCID_DATA_P0_LSB 1
`define TCID_BRANCH_BC_BIT 5
`define TCID_FIXED_ONE_BIT 0

// field values
`define TCID_TS_SIZE_64 5'h08
`define TCID_EVT_CNT_FOUR 2'h3
`define TCID_ZERO_REG 64'h0
`define TCID_EXC_CLASS 6'h18

`endif

// *** tcid_pkg.sv ***
package tcid_pkg;
  typedef enum logic [1:0] {
    TCID_EL0,
    TCID_EL1,
    TCID_EL2,
    TCID_EL3
  } tcid_el_t;

  typedef enum logic [1:0] {
    TCID_RES_DATA,
    TCID_RES_UNDEF,
    TCID_RES_TRAP
  } tcid_res_t;
endpackage : tcid_pkg

// *** tcid_top.sv ***
// Behaviour
// - reads at user level are undefined and return no value
// - at level 1 the level-1 trace trap goes to level 1, class 0x18, first
// - at level 1, EL2 on and level-2 trace trap set: trap to level 2
// - at level 1, EL2 on, fine trap enabled, id read trap bit: level 2
// - levels 1 to 3, nothing earlier, level-3 trace trap set: level 3
// - at level 2 the level-2 trace trap is checked first; no fine trap
// - id registers ten to thirteen read as zero, also after reset
// - main id transaction-start bit reads zero
// - main id commit-option bit reads one
// - main id timestamp size reports 64-bit global timestamps
// - main id q-element support and filter fields read zero
// - main id event count reads binary 11, four events
// - main id return-stack bit reads one
// - main id cycle-counting bit reads one
// - main id conditional, data trace and load/store p0 fields read zero
// - main id branch-broadcast bit reads one
`timescale 1ns/10ps
`include "tcid_cfg.svh"

module tcid_top
  import tcid_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_rd_req,
  input wire logic [`TCID_SEL_W-1:0] i_rd_sel,
  input wire logic [1:0] i_current_exception_level,
  input wire logic i_el2_enabled,
  input wire logic i_l1_trace_access_trap_bit,
  input wire logic i_l2_trace_access_trap_bit,
  input wire logic i_l3_trace_access_trap_bit,
  input wire logic i_fine_grain_trap_enable,
  input wire logic i_trace_id_read_trap_bit,
  output logic o_rd_done,
  output logic o_rd_hit,
  output logic [63:0] o_rd_data,
  output logic o_undef,
  output logic o_trap,
  output logic [1:0] o_trap_level,
  output logic [5:0] o_trap_class
);

  // ---------------------------------------------
  // assertion defaults
  // ---------------------------------------------
  default clocking chk_cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_n);

  // ---------------------------------------------
  // register contents
  // ---------------------------------------------
  logic [63:0] main_id;
  always_comb begin
    main_id = `TCID_ZERO_REG;
    main_id[`TCID_TRANS_KIND_BIT] = 1'b0;
    main_id[`TCID_COMMIT_OPT_BIT] = 1'b1;
    main_id[`TCID_TS_SIZE_LSB +: 5] = `TCID_TS_SIZE_64;
    main_id[`TCID_Q_ELEM_LSB +: 3] = 3'h0;
    main_id[`TCID_EVT_CNT_LSB +: 2] = `TCID_EVT_CNT_FOUR;
    main_id[`TCID_RET_STACK_BIT] = 1'b1;
    main_id[`TCID_CYC_CNT_BIT] = 1'b1;
    main_id[`TCID_COND_TRACE_BIT] = 1'b0;
    main_id[`TCID_DATA_P0_LSB +: 4] = 4'h0;
    main_id[`TCID_BRANCH_BC_BIT] = 1'b1;
    main_id[`TCID_FIXED_ONE_BIT] = 1'b1;
  end

  logic hit;
  logic [63:0] sel_data;
  always_comb begin
    hit = 1'b1;
    sel_data = `TCID_ZERO_REG;
    unique case (i_rd_sel)
      `TCID_SEL_ID_TEN,
      `TCID_SEL_ID_ELEVEN,
      `TCID_SEL_ID_TWELVE,
      `TCID_SEL_ID_THIRTEEN: sel_data = `TCID_ZERO_REG;
      `TCID_SEL_ID_MAIN: sel_data = main_id;
      default: hit = 1'b0;
    endcase
  end

  // ---------------------------------------------
  // access check
  // ---------------------------------------------
  // priority chain mirrors the architectural check order
  tcid_el_t el;
  tcid_res_t res;
  logic [1:0] tgt;
  assign el = tcid_el_t'(i_current_exception_level);
  always_comb begin
    res = TCID_RES_DATA;
    tgt = 2'h0;
    unique case (el)
      TCID_EL0: res = TCID_RES_UNDEF;
      TCID_EL1: begin
        if (i_l1_trace_access_trap_bit) begin
          res = TCID_RES_TRAP;
          tgt = 2'h1;
        end else if (i_el2_enabled && i_l2_trace_access_trap_bit) begin
          res = TCID_RES_TRAP;
          tgt = 2'h2;
        end else if (i_el2_enabled && i_fine_grain_trap_enable &&
                     i_trace_id_read_trap_bit) begin
          res = TCID_RES_TRAP;
          tgt = 2'h2;
        end else if (i_l3_trace_access_trap_bit) begin
          res = TCID_RES_TRAP;
          tgt = 2'h3;
        end
      end
      TCID_EL2: begin
        // fine-grained trap deliberately not looked at here
        if (i_l2_trace_access_trap_bit) begin
          res = TCID_RES_TRAP;
          tgt = 2'h2;
        end else if (i_l3_trace_access_trap_bit) begin
          res = TCID_RES_TRAP;
          tgt = 2'h3;
        end
      end
      TCID_EL3: begin
        if (i_l3_trace_access_trap_bit) begin
          res = TCID_RES_TRAP;
          tgt = 2'h3;
        end
      end
    endcase
  end

  // ---------------------------------------------
  // answer registers
  // ---------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rd_done <= 1'b0;
      o_rd_hit <= 1'b0;
    end else begin
      o_rd_done <= i_rd_req;
      o_rd_hit <= i_rd_req && hit;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rd_data <= `TCID_ZERO_REG;
    end else if (i_rd_req && res == TCID_RES_DATA) begin
      o_rd_data <= sel_data;
    end else begin
      // nothing leaks out on refused reads
      o_rd_data <= `TCID_ZERO_REG;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_undef <= 1'b0;
      o_trap <= 1'b0;
      o_trap_level <= 2'h0;
      o_trap_class <= 6'h0;
    end else begin
      o_undef <= i_rd_req && res == TCID_RES_UNDEF;
      o_trap <= i_rd_req && res == TCID_RES_TRAP;
      o_trap_level <= (i_rd_req && res == TCID_RES_TRAP) ? tgt : 2'h0;
      o_trap_class <= (i_rd_req && res == TCID_RES_TRAP) ?
                      `TCID_EXC_CLASS : 6'h0;
    end
  end

  // ---------------------------------------------
  // checks
  // ---------------------------------------------
  sequence req_at_user_s;
    i_rd_req && i_current_exception_level == 2'h0;
  endsequence

  sequence answer_undef_s;
    o_undef && !o_trap && o_rd_data == 64'h0;
  endsequence

  // a trapped read carries the class but never register bits
  sequence answer_trap_l1_s;
    o_trap && !o_undef && o_trap_level == 2'h1 &&
    o_trap_class == 6'h18 && o_rd_data == 64'h0;
  endsequence

  sequence answer_trap_l2_s;
    o_trap && !o_undef && o_trap_level == 2'h2 &&
    o_trap_class == 6'h18 && o_rd_data == 64'h0;
  endsequence

  sequence answer_trap_l3_s;
    o_trap && !o_undef && o_trap_level == 2'h3 &&
    o_trap_class == 6'h18 && o_rd_data == 64'h0;
  endsequence

  // level 3 with its trap clear always returns the register
  sequence main_granted_s;
    i_rd_req && i_rd_sel == `TCID_SEL_ID_MAIN &&
    i_current_exception_level == 2'h3 && !i_l3_trace_access_trap_bit;
  endsequence

  user_undef_a: assert property (
    req_at_user_s |=> answer_undef_s)
    else $error("user level read not undefined");

  undef_only_user_a: assert property (
    i_rd_req && i_current_exception_level != 2'h0 |=> !o_undef)
    else $error("undefined outside user level");

  l1_trap_a: assert property (
    i_rd_req && i_current_exception_level == 2'h1 &&
    i_l1_trace_access_trap_bit |=> answer_trap_l1_s)
    else $error("level 1 trap wrong");

  trap_class_a: assert property (
    !o_trap |-> o_trap_class == 6'h0 && o_trap_level == 2'h0)
    else $error("trap class shown without trap");

  l2_from_l1_a: assert property (
    i_rd_req && i_current_exception_level == 2'h1 &&
    !i_l1_trace_access_trap_bit && i_el2_enabled &&
    i_l2_trace_access_trap_bit |=> answer_trap_l2_s)
    else $error("level 2 trap from level 1 wrong");

  no_el2_l2_a: assert property (
    i_rd_req && i_current_exception_level == 2'h1 && !i_el2_enabled &&
    !i_l1_trace_access_trap_bit && !i_l3_trace_access_trap_bit |=>
    !o_trap)
    else $error("level 2 trap taken with el2 off");

  fine_trap_a: assert property (
    i_rd_req && i_current_exception_level == 2'h1 &&
    !i_l1_trace_access_trap_bit && i_el2_enabled &&
    i_fine_grain_trap_enable && i_trace_id_read_trap_bit |=>
    answer_trap_l2_s)
    else $error("fine grained trap wrong");

  fine_off_a: assert property (
    i_rd_req && i_current_exception_level == 2'h1 &&
    !i_l1_trace_access_trap_bit && !i_l2_trace_access_trap_bit &&
    !i_l3_trace_access_trap_bit && !(i_el2_enabled &&
    i_fine_grain_trap_enable && i_trace_id_read_trap_bit) |=>
    !o_trap && !o_undef)
    else $error("level 1 read trapped without cause");

  l3_from_l1_a: assert property (
    i_rd_req && i_current_exception_level == 2'h1 &&
    !i_l1_trace_access_trap_bit && !i_l2_trace_access_trap_bit &&
    !i_trace_id_read_trap_bit && i_l3_trace_access_trap_bit |=>
    answer_trap_l3_s)
    else $error("level 3 trap from level 1 wrong");

  l3_from_l2_a: assert property (
    i_rd_req && i_current_exception_level == 2'h2 &&
    !i_l2_trace_access_trap_bit && i_l3_trace_access_trap_bit |=>
    answer_trap_l3_s)
    else $error("level 3 trap from level 2 wrong");

  l3_trap_a: assert property (
    i_rd_req && i_current_exception_level == 2'h3 &&
    i_l3_trace_access_trap_bit |=> answer_trap_l3_s)
    else $error("level 3 trap wrong");

  l2_trap_a: assert property (
    i_rd_req && i_current_exception_level == 2'h2 &&
    i_l2_trace_access_trap_bit |=> answer_trap_l2_s)
    else $error("level 2 trap wrong");

  // level 2 ignores the fine-grained controls entirely
  el2_no_fine_a: assert property (
    i_rd_req && i_current_exception_level == 2'h2 &&
    !i_l2_trace_access_trap_bit && !i_l3_trace_access_trap_bit |=>
    !o_trap && !o_undef)
    else $error("level 2 read trapped by fine control");

  done_pulse_a: assert property (
    i_rd_req |=> o_rd_done)
    else $error("read not answered");

  idle_quiet_a: assert property (
    !i_rd_req |=> !o_rd_done && !o_rd_hit && !o_undef && !o_trap &&
    o_rd_data == 64'h0)
    else $error("answer without a request");

  main_value_a: assert property (
    main_granted_s |=> o_rd_hit && o_rd_data == 64'h0000_0000_2800_0ea1)
    else $error("main id value wrong");

  unmapped_a: assert property (
    i_rd_req && i_current_exception_level == 2'h3 &&
    !i_l3_trace_access_trap_bit && i_rd_sel == 16'h8857 |=>
    o_rd_done && !o_rd_hit && o_rd_data == 64'h0)
    else $error("unmapped selector returned data");

  zero_regs_a: assert property (
    i_rd_req && i_rd_sel == `TCID_SEL_ID_TEN |=> o_rd_data == 64'h0)
    else $error("id ten not zero");

  zero_rest_a: assert property (
    i_rd_req && (i_rd_sel == `TCID_SEL_ID_ELEVEN ||
    i_rd_sel == `TCID_SEL_ID_TWELVE ||
    i_rd_sel == `TCID_SEL_ID_THIRTEEN) |=> o_rd_hit && o_rd_data == 64'h0)
    else $error("id eleven to thirteen not zero");

  trans_kind_a: assert property (
    main_granted_s |=> !o_rd_data[30])
    else $error("transaction start bit not zero");

  commit_opt_a: assert property (
    main_granted_s |=> o_rd_data[29])
    else $error("commit option bit not one");

  ts_size_a: assert property (
    main_granted_s |=> o_rd_data[28:24] == 5'h08)
    else $error("timestamp size wrong");

  q_elem_a: assert property (
    main_granted_s |=> o_rd_data[16:14] == 3'h0)
    else $error("q element fields not zero");

  event_cnt_a: assert property (
    main_granted_s |=> o_rd_data[11:10] == 2'h3)
    else $error("event count wrong");

  ret_stack_a: assert property (
    main_granted_s |=> o_rd_data[9])
    else $error("return stack bit not one");

  cyc_cnt_a: assert property (
    main_granted_s |=> o_rd_data[7])
    else $error("cycle counting bit not one");

  unimpl_zero_a: assert property (
    main_granted_s |=> !o_rd_data[6] && o_rd_data[4:1] == 4'h0)
    else $error("unimplemented trace fields not zero");

  branch_bc_a: assert property (
    main_granted_s |=> o_rd_data[5])
    else $error("branch broadcast bit not one");

  reserved_a: assert property (
    main_granted_s |=> o_rd_data[0] && !o_rd_data[8] &&
    o_rd_data[63:31] == 33'h0 && o_rd_data[23:17] == 7'h0 &&
    o_rd_data[13:12] == 2'h0)
    else $error("main id reserved bits wrong");

endmodule : tcid_top

// *** tcid_core_model.sv ***
`timescale 1ns/10ps
// -----------------------------------------
// core side read issue
// -----------------------------------------
module tcid_core_model (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_go,
  input wire logic [15:0] i_sel,
  input wire logic [7:0] i_ctl,
  output logic o_rd_req,
  output logic [15:0] o_rd_sel,
  output logic [7:0] o_ctl
);
  // selector is scrambled while idle so a stale value never passes
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rd_req <= 1'b0;
      o_rd_sel <= 16'h0;
      o_ctl <= 8'h0;
    end else begin
      o_rd_req <= i_go;
      o_rd_sel <= i_go ? i_sel : ~i_sel;
      o_ctl <= i_ctl;
    end
  end
endmodule : tcid_core_model

// *** tb_trace_capability_id_readout.sv ***
`timescale 1ns/10ps
`include "tcid_cfg.svh"
module tb_trace_capability_id_readout;
  logic i_ref_clk = 1'b0;
  logic i_rst_n;
  logic go = 1'b0;
  logic [15:0] sel = 16'h0;
  logic [7:0] ctl = 8'h0;
  logic rd_req;
  logic [15:0] rd_sel;
  logic [7:0] m_ctl;
  logic done, hit, undef, trap;
  logic [1:0] lvl;
  logic [5:0] cls;
  logic [63:0] data;
  int err_total = 0;
  int cmp_count = 0;
  int cyc = 0;
  logic [15:0] sels [6] = '{`TCID_SEL_ID_TEN, `TCID_SEL_ID_ELEVEN,
    `TCID_SEL_ID_TWELVE, `TCID_SEL_ID_THIRTEEN, `TCID_SEL_ID_MAIN, 16'h8857};
  localparam logic [63:0] MAIN_ID = (64'h1 << 29) | (64'h08 << 24)
    | (64'h3 << 10) | (64'h1 << 9) | (64'h1 << 7) | (64'h1 << 5) | 64'h1;

  tcid_core_model core (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
    .i_go(go), .i_sel(sel), .i_ctl(ctl), .o_rd_req(rd_req),
    .o_rd_sel(rd_sel), .o_ctl(m_ctl));
  tcid_top dut (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_rd_req(rd_req),
    .i_rd_sel(rd_sel), .i_current_exception_level(m_ctl[1:0]),
    .i_el2_enabled(m_ctl[2]), .i_l1_trace_access_trap_bit(m_ctl[3]),
    .i_l2_trace_access_trap_bit(m_ctl[4]),
    .i_l3_trace_access_trap_bit(m_ctl[5]),
    .i_fine_grain_trap_enable(m_ctl[6]),
    .i_trace_id_read_trap_bit(m_ctl[7]), .o_rd_done(done), .o_rd_hit(hit),
    .o_rd_data(data), .o_undef(undef), .o_trap(trap), .o_trap_level(lvl),
    .o_trap_class(cls));

  // -----------------------------------------
  // checking helpers
  // -----------------------------------------
  task automatic print_verdict();
    if (err_total == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // {undef, trap, level}; checks in priority order per level
  function automatic logic [3:0] ref_res(input logic [7:0] c);
    if (c[1:0] == 2'h0) return 4'h8;
    if (c[1:0] == 2'h1 && c[3]) return 4'h5;
    if (c[1:0] != 2'h3 && (c[1:0] == 2'h2 || c[2]) && c[4]) return 4'h6;
    if (c[1:0] == 2'h1 && c[2] && c[6] && c[7]) return 4'h6;
    if (c[5]) return 4'h7;
    return 4'h0;
  endfunction : ref_res

  task automatic rd(input logic [15:0] s, input logic [7:0] c);
    logic [3:0] r;
    logic [63:0] d;
    r = ref_res(c);
    d = (s == `TCID_SEL_ID_MAIN && r == 4'h0) ? MAIN_ID : 64'h0;
    go = 1'b1;
    sel = s;
    ctl = c;
    @(posedge i_ref_clk);
    #1 go = 1'b0;
    @(posedge i_ref_clk);
    #1;
    chk({done, hit, undef, trap, lvl, cls}, {1'b1, s !== sels[5], r[3],
      r[2], r[1:0], r[2] ? 6'h18 : 6'h0});
    chk(data, d);
    chk(data & 64'hffff_ffff_8000_4fff, d & 64'hea1);
    chk(data & 64'hfe_3121, d & 64'h21);
  endtask : rd

  // -----------------------------------------
  // clock, timeout and sequence
  // -----------------------------------------
  initial begin
    forever #2 i_ref_clk = ~i_ref_clk;
  end

  // 1536 reads of two cycles each plus reset
  always @(posedge i_ref_clk) begin
    cyc++;
    if (cyc == 4000) begin
      err_total++;
      print_verdict();
    end
  end

  initial begin
    i_rst_n = 1'b0;
    repeat (20) @(posedge i_ref_clk);
    #1 chk({done, hit, undef, trap, lvl, cls}, 64'h0);
    chk(data, 64'h0);
    i_rst_n = 1'b1;
    for (int k = 0; k < 6; k++) begin
      for (int c = 0; c < 256; c++) begin
        rd(sels[k], c[7:0]);
      end
    end
    print_verdict();
  end
endmodule : tb_trace_capability_id_readout
